// File: design/iod_pkg.sv
// package of constants for the i2c octal open-drain driver
package iod_pkg;
    // ----------------------------------------
    // address and data layout
    // ----------------------------------------
    localparam int          ADDR_W          = 7;
    localparam int          SEL_W           = 3;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  FIXED_ADDR_BITS = 4'h7;       // upper address nibble 0111
    localparam logic        RW_WRITE        = 1'h0;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;      // all outputs on (pulled low)
    localparam logic [3:0]  BIT_LAST        = 4'h7;       // index of last bit of a byte
    localparam logic [3:0]  BIT_ZERO        = 4'h0;
    localparam int          SYNC_STAGES     = 2;

    // ----------------------------------------
    // receiver states, gray along the usual path
    // ----------------------------------------
    typedef enum logic [2:0] {
        IOD_IDLE  = 3'h0,
        IOD_ADDR  = 3'h1,
        IOD_AACK  = 3'h3,
        IOD_DATA  = 3'h2,
        IOD_DACK  = 3'h6
    } iod_state_t;
endpackage

// File: design/iod_sync.sv
// two flip-flop synchroniser for one bus line
`timescale 1ns/10ps
module iod_sync
    import iod_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // line
    input  wire logic d_in,
    output logic      q_out
);
    logic [SYNC_STAGES-1:0] stage_reg;
    logic [SYNC_STAGES-1:0] stage_next;

    // shift the line through the chain
    always_comb begin
        stage_next = {stage_reg[SYNC_STAGES-2:0], d_in};
    end

    // register the chain; idle bus level is high
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage_reg <= '1;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign q_out = stage_reg[SYNC_STAGES-1];
endmodule // iod_sync

// File: design/iod_top.sv
// i2c write-only slave driving eight open-drain outputs
//
// Function
// - detect start, SDA falls while SCL high
// - detect stop, SDA rises while SCL high
// - pull SDA low through ninth pulse
// - compare 7-bit address, sent MSB first
// - upper address bits fixed at 0111
// - low address bits follow select pins
// - accept only when read/write bit 0
// - bit 1 releases output, 0 pulls low
// - repeated start restarts the address phase
// - after reset all outputs pulled low
`timescale 1ns/10ps
module iod_top
    import iod_pkg::*;
(
    // system clock and reset
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RSTN_IN,
    // i2c bus (sda is open drain: oe low means drive low)
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    output logic                   SDA_OUT,
    output logic                   SDA_OE_N_OUT,
    // address select pins (pulled up off chip)
    input  wire logic [SEL_W-1:0]  ADDR_SELECT_PINS_IN,
    // open-drain outputs: value and low-active enable
    output logic [DATA_W-1:0]      DRAIN_OUTPUTS_OUT,
    output logic [DATA_W-1:0]      DRAIN_OUTPUTS_OE_N_OUT
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic scl_s;
    logic sda_s;
    logic [SEL_W-1:0] sel_s;

    iod_sync u_sync_scl (.clk_in(CLK_SYS_IN), .rstn_in(RSTN_IN), .d_in(SCL_IN), .q_out(scl_s));
    iod_sync u_sync_sda (.clk_in(CLK_SYS_IN), .rstn_in(RSTN_IN), .d_in(SDA_IN), .q_out(sda_s));

    genvar gi;
    generate
        for (gi = 0; gi < SEL_W; gi++) begin : g_sel
            iod_sync u_sync_sel (.clk_in(CLK_SYS_IN), .rstn_in(RSTN_IN), .d_in(ADDR_SELECT_PINS_IN[gi]),
                                 .q_out(sel_s[gi]));
        end
    endgenerate

    // ----------------------------------------
    // edge and condition detection
    // ----------------------------------------
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // delayed copies of the synchronised lines
    // reset to the idle bus level so no false edge follows reset
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // start and stop are sda edges while scl stays high
    // both lines pass equal synchroniser stages, so their order at the pins
    // is kept and a data change in scl low never looks like a start
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ----------------------------------------
    // receiver state machine
    // ----------------------------------------
    // bit_cnt counts scl rises inside a byte and reaches eight after the
    // last bit; the following scl fall closes the byte. shift gathers the
    // byte msb first. latch holds the last complete data byte and feeds the
    // output enables directly. ack marks that the slave pulls sda low, and
    // ack_seen remembers that the ninth pulse has risen, so the release
    // waits for the fall that ends that pulse. sda_oe_n is the pin copy of
    // ack, kept in its own flop so the pin comes straight from a register.
    iod_state_t        state_reg,    state_next;
    logic [3:0]        bit_cnt_reg,  bit_cnt_next;
    logic [DATA_W-1:0] shift_reg,    shift_next;
    logic [DATA_W-1:0] latch_reg,    latch_next;
    logic              ack_reg,      ack_next;
    logic              ack_seen_reg, ack_seen_next;
    logic              sda_oe_n_reg, sda_oe_n_next;
    logic [ADDR_W-1:0] own_addr;

    // own address: fixed nibble plus select pins; an open select pin reads
    // as 1 through its pull-up
    assign own_addr = {FIXED_ADDR_BITS, sel_s};

    // one byte takes nine scl pulses: eight bits are shifted in on the
    // synchronised rises, and the fall after the eighth opens the ack. the
    // ack is held until the fall that ends the ninth pulse, so sda never
    // moves while scl is high. a start or stop seen at any point wins over
    // the byte in progress, which keeps a cut transfer from leaving the
    // receiver stuck half way through a byte.

    // next-state logic, one bit per scl rise, sda changes on scl fall
    always_comb begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        latch_next    = latch_reg;
        ack_next      = ack_reg;
        ack_seen_next = ack_seen_reg;
        if (start_det) begin
            // start or repeated start returns to address phase
            state_next   = IOD_ADDR;
            bit_cnt_next = BIT_ZERO;
            ack_next     = 1'h0;
        end else if (stop_det) begin
            // stop ends the transfer; a partial byte is dropped
            state_next   = IOD_IDLE;
            ack_next     = 1'h0;
        end else begin
            case (state_reg)
                IOD_IDLE: begin
                    // deaf until the next start
                    ack_next = 1'h0;
                end
                IOD_ADDR, IOD_DATA: begin
                    if (scl_rise) begin
                        // msb first shift
                        shift_next   = {shift_reg[DATA_W-2:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg > BIT_LAST) begin
                        // the fall after the eighth bit closes the byte
                        bit_cnt_next  = BIT_ZERO;
                        ack_seen_next = 1'h0;
                        if (state_reg == IOD_ADDR) begin
                            // address byte: seven address bits, then read/write
                            if (shift_reg[DATA_W-1:1] == own_addr && shift_reg[0] == RW_WRITE) begin
                                state_next = IOD_AACK;
                                ack_next   = 1'h1;
                            end else begin
                                // not ours or a read: stay off the bus
                                state_next = IOD_IDLE;
                            end
                        end else begin
                            // data byte: the whole byte moves to the latch at once
                            latch_next = shift_reg;
                            state_next = IOD_DACK;
                            ack_next   = 1'h1;
                        end
                    end
                end
                IOD_AACK, IOD_DACK: begin
                    // hold sda low through the whole ninth pulse
                    if (scl_rise) begin
                        ack_seen_next = 1'h1;
                    end else if (scl_fall && ack_seen_reg) begin
                        // release only on the fall that ends the ninth pulse
                        ack_next   = 1'h0;
                        state_next = IOD_DATA;
                    end
                end
                default: begin
                    // unused codes fall back to idle
                    state_next = IOD_IDLE;
                    ack_next   = 1'h0;
                end
            endcase
        end
        // sda enable is low while the ack is held
        sda_oe_n_next = ~ack_next;
    end

    // register the receiver state
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            // bus released, all outputs on
            state_reg    <= IOD_IDLE;
            bit_cnt_reg  <= BIT_ZERO;
            shift_reg    <= LATCH_RESET;
            latch_reg    <= LATCH_RESET;
            ack_reg      <= 1'h0;
            ack_seen_reg <= 1'h0;
            sda_oe_n_reg <= 1'h1;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            latch_reg    <= latch_next;
            ack_reg      <= ack_next;
            ack_seen_reg <= ack_seen_next;
            sda_oe_n_reg <= sda_oe_n_next;
        end
    end

    // ----------------------------------------
    // pin drivers, enables straight from flip-flops
    // ----------------------------------------
    // both open-drain pins only ever pull low, so their drive values are
    // tied low and the enables alone carry the state
    assign SDA_OUT                = 1'h0;
    // sda enable: low while the ack is held
    assign SDA_OE_N_OUT           = sda_oe_n_reg;
    assign DRAIN_OUTPUTS_OUT      = '0;
    // output enables: a latch bit of 1 releases its pin, 0 pulls it low,
    // and the reset value leaves every output on
    assign DRAIN_OUTPUTS_OE_N_OUT = latch_reg;
endmodule // iod_top

// File: tb/iod_asserts.sv
// port checks for the octal open-drain driver
`timescale 1ns/10ps
module iod_asserts
    import iod_pkg::*;
(
    input wire logic              CLK_SYS_IN,
    input wire logic              RSTN_IN,
    input wire logic              SCL_IN,
    input wire logic              SDA_OUT,
    input wire logic              SDA_OE_N_OUT,
    input wire logic [DATA_W-1:0] DRAIN_OUTPUTS_OUT,
    input wire logic [DATA_W-1:0] DRAIN_OUTPUTS_OE_N_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);
    // ack opens in scl low and closes one scl period later
    sequence ack_open; $fell(SDA_OE_N_OUT) && !SCL_IN; endsequence
    sequence ack_close; ##[20:40] ($rose(SDA_OE_N_OUT) && !SCL_IN); endsequence
    chk_ack_pulse_len: assert property (ack_open |-> ack_close)
        else $error("ack pulse length wrong");
    chk_ack_after_pulse: assert property ($fell(SDA_OE_N_OUT) |-> $past(SCL_IN, 8))
        else $error("ack not after a clock pulse");
    chk_ack_ends_low: assert property ($rose(SDA_OE_N_OUT) |-> !SCL_IN)
        else $error("ack released in scl high");
    chk_latch_at_ack: assert property ($changed(DRAIN_OUTPUTS_OE_N_OUT) |-> $fell(SDA_OE_N_OUT))
        else $error("latch moved without ack");
    chk_latch_scl_high: assert property (SCL_IN |-> $stable(DRAIN_OUTPUTS_OE_N_OUT))
        else $error("latch moved in scl high");
    chk_reset_all_on: assert property ($rose(RSTN_IN) |-> DRAIN_OUTPUTS_OE_N_OUT == LATCH_RESET)
        else $error("outputs not on after reset");
    chk_sda_drive_low: assert property (SDA_OUT == 1'h0)
        else $error("sda drive value not low");
    chk_drain_drive_low: assert property (DRAIN_OUTPUTS_OUT == 8'h00)
        else $error("output drive value not low");
endmodule // iod_asserts

bind iod_top iod_asserts u_chk (
    .CLK_SYS_IN(CLK_SYS_IN),
    .RSTN_IN(RSTN_IN),
    .SCL_IN(SCL_IN),
    .SDA_OUT(SDA_OUT),
    .SDA_OE_N_OUT(SDA_OE_N_OUT),
    .DRAIN_OUTPUTS_OUT(DRAIN_OUTPUTS_OUT),
    .DRAIN_OUTPUTS_OE_N_OUT(DRAIN_OUTPUTS_OE_N_OUT)
);

// File: tb/iod_master.sv
// behavioural i2c bus master, scl half period 16 clocks
`timescale 1ns/10ps
module iod_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out = 1'h1;
        sda_low_out = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // start or repeated start: sda falls in scl high
    task automatic start_bus();
        tick(4);
        sda_low_out = 1'h0;
        tick(12);
        scl_out = 1'h1;
        tick(16);
        sda_low_out = 1'h1;
        tick(16);
        scl_out = 1'h0;
    endtask
    // stop: sda rises in scl high, also after a missing ack
    task automatic stop_bus();
        tick(4);
        sda_low_out = 1'h1;
        tick(12);
        scl_out = 1'h1;
        tick(16);
        sda_low_out = 1'h0;
        tick(16);
    endtask
    task automatic send_bit(input logic b);
        tick(4);
        sda_low_out = !b;
        tick(12);
        scl_out = 1'h1;
        tick(16);
        scl_out = 1'h0;
    endtask
    // byte msb first, then release sda for the ack pulse
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
        tick(4);
        sda_low_out = 1'h0;
        tick(12);
        scl_out = 1'h1;
        tick(8);
        ack = !sda_in;
        tick(8);
        scl_out = 1'h0;
    endtask
endmodule // iod_master

// File: tb/test_iod_top.sv
// self-checking bench for the octal open-drain driver
`timescale 1ns/10ps
module test_iod_top;
    import iod_pkg::*;
    logic              clk = 1'h0;
    logic              rstn = 1'h0;
    logic              scl, sda_low, oe_n, drv, a;
    logic              sel_en = 1'h1; // 0 leaves pins to pull-ups
    logic [SEL_W-1:0]  sel_val = 3'h0;
    logic [DATA_W-1:0] q_oe_n, q_exp = 8'h00;
    int n_fail = 0, check_count = 0, cycles = 0, seed = 26193;
    wire sda = ~sda_low & (oe_n | drv);
    wire [SEL_W-1:0] pins = sel_en ? sel_val : 3'h7;
    always #2.5 clk = ~clk;
    iod_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    iod_top dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(drv),
        .SDA_OE_N_OUT(oe_n), .ADDR_SELECT_PINS_IN(pins), .DRAIN_OUTPUTS_OUT(),
        .DRAIN_OUTPUTS_OE_N_OUT(q_oe_n));
    // --------
    // helpers
    // --------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    function logic [7:0] addr_byte(input logic [2:0] sel, input logic rd);
        return {FIXED_ADDR_BITS, sel, rd};
    endfunction
    task finish_test();
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task xfer(input logic [7:0] ab, input logic [7:0] d, input logic hit);
        m.start_bus();
        m.send_byte(ab, a);
        check({7'h00, a}, {7'h00, hit});
        // data follows even when refused: it must neither be acked nor land
        m.send_byte(d, a);
        if (hit) q_exp = d;
        check({7'h00, a}, {7'h00, hit});
        check(q_oe_n, q_exp);
    endtask
    always @(posedge clk) if (++cycles == 30000) begin
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'h1;
        repeat (4) @(negedge clk);
        check(q_oe_n, 8'h00);
        for (int s = 0; s < 8; s++) begin
            sel_val = 3'(s);
            sel_en = (s != 7);
            xfer(addr_byte(3'(s), RW_WRITE), 8'($random(seed)), 1'h1);
            m.stop_bus();
        end
        sel_val = 3'h5;
        sel_en = 1'h1;
        xfer(addr_byte(3'h4, 1'h0), 8'h5a, 1'h0);
        m.stop_bus();
        xfer(addr_byte(3'h5, 1'h1), 8'h5a, 1'h0);
        m.stop_bus();
        xfer(addr_byte(3'h5, 1'h0), 8'hff, 1'h1);
        m.send_byte(8'hc3, a);
        check({7'h00, a}, 8'h01);
        check(q_oe_n, 8'hc3);
        q_exp = 8'hc3;
        xfer(addr_byte(3'h5, 1'h0), 8'h81, 1'h1);
        m.start_bus();
        m.send_byte(addr_byte(3'h5, 1'h0), a);
        m.send_bit(1'h1);
        m.send_bit(1'h0);
        m.stop_bus();
        check(q_oe_n, q_exp);
        finish_test();
    end
endmodule // test_iod_top
